// File: verilog/eio_io_unit.sv
// eight channel io readout unit with wishbone registers
`timescale 1ns/1ns
`include "eio_defines.svh"
// three channel groups sit behind one wishbone register bus:
//   eight filtered digital inputs, eight digital outputs, and
//   eight analog channels that a converter port scans without pause
// each group keeps a sticky per channel change mask and one status bit;
//   the interrupt is high while any enabled status bit is set
// every access is answered two cycles after it is first seen, which
//   gives the raw value store one cycle to bring out its word
// a limitation: the event value of a channel only moves on an event,
//   so a drift that stays within the threshold never raises one
// the reference mode is write only; software must set it after start

module eio_io_unit (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // digital inputs, high while activated
  input wire logic [7:0] din_i,
  // digital outputs, high activates
  output logic [7:0] dout_o,
  // converter port
  output logic adc_start_o,
  output logic [2:0] adc_chan_o,
  output logic adc_ref_ratio_o,
  input wire logic [9:0] adc_sample_i,
  input wire logic adc_valid_i,
  // interrupt
  output logic irq_o
);

  //////////////////////////////////////////////////////////////////////
  // declarations

  eio_pkg::eio_core_type s; // registered state
  eio_pkg::eio_core_type next_s; // next state
  // terms of the bus side
  logic [7:0] din_level; // filtered input levels
  logic [11:0] raw_rd; // raw word for the bus
  logic [31:0] rd; // read value of the addressed register
  logic hit; // address is mapped
  logic [2:0] idx; // channel index of a page access
  logic [2:0] pg; // page of the address
  logic [31:0] bm; // byte lane mask
  logic [31:0] wm; // masked write data
  logic do_wr; // write takes effect now
  logic [31:0] dout_wr; // drive word after the lane merge
  logic [31:0] thr_wr; // threshold word after the lane merge
  // terms of the event side
  logic [7:0] in_clr; // clears of the change masks
  logic [7:0] out_clr;
  logic [7:0] an_clr;
  logic [2:0] irq_clr;
  logic [7:0] in_set; // new change events
  logic [7:0] out_set;
  logic [7:0] an_set;
  // terms of the analog check
  logic [9:0] scaled; // scaled value of the finished sum
  logic [9:0] delta; // move since the last event

  //////////////////////////////////////////////////////////////////////
  // helpers

  // raw to 0..1000; the product peaks at 4099095, below 2**22
  // the result truncates rather than rounds; the error stays below one step
  function automatic logic [9:0] eio_scale(input logic [11:0] raw);
    logic [21:0] p;
    p = {10'h000, raw} * `EIO_SCALE_MUL;
    return p[21:12];
  endfunction : eio_scale

  // keep old bits in lanes that are not selected
  // used for every register whose lanes can be written one at a time
  function automatic logic [31:0] eio_merge(input logic [31:0] cur, input logic [31:0] m,
                                           input logic [31:0] w);
    return (cur & ~m) | w;
  endfunction : eio_merge

  //////////////////////////////////////////////////////////////////////
  // sub blocks

  // input noise filter
  // a level must stand still for the whole filter time before it counts
  eio_din_filter u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(din_i),
    .level_o(din_level)
  );

  // raw value store; bus reads it, the scan writes it
  // written once per channel scan, so a read always sees a whole sum
  eio_raw_mem u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(s.adc_st == eio_pkg::EIO_ADC_STORE),
    .waddr_i(s.chan),
    .wdata_i(s.acc),
    .raddr_i(wb_adr_i[4:2]),
    .rdata_o(raw_rd)
  );

  //////////////////////////////////////////////////////////////////////
  // read decode

  // the addressed register, from state only
  always_comb begin
    rd = 32'h0000_0000;
    hit = 1'b1;
    idx = wb_adr_i[4:2];
    pg = wb_adr_i[7:5];
    // single registers sit below the pages; a page of eight words is
    // chosen by address bits 7:5 and its channel by bits 4:2
    case (wb_adr_i)
      `EIO_OFF_DIN: begin
        rd = {24'h00_0000, din_level};
      end
      `EIO_OFF_DOUT: begin
        rd = {24'h00_0000, s.dout};
      end
      `EIO_OFF_CONFIG: begin
        rd = 32'h0000_0000; // mode is not reported back
      end
      `EIO_OFF_IRQ_STAT: begin
        rd = {29'h0000_0000, s.irq_stat};
      end
      `EIO_OFF_IRQ_CLR: begin
        rd = 32'h0000_0000; // write only
      end
      `EIO_OFF_IRQ_EN: begin
        rd = {29'h0000_0000, s.irq_en};
      end
      `EIO_OFF_IN_CHG: begin
        rd = {24'h00_0000, s.in_chg};
      end
      `EIO_OFF_OUT_CHG: begin
        rd = {24'h00_0000, s.out_chg};
      end
      `EIO_OFF_AN_CHG: begin
        rd = {24'h00_0000, s.an_chg};
      end
      default: begin
        if (wb_adr_i[1:0] != 2'h0) begin
          hit = 1'b0; // misaligned
        end else if (pg == `EIO_PG_THRESH) begin
          rd = {22'h00_0000, s.thresh[idx]};
        end else if (pg == `EIO_PG_ANALOG) begin
          rd = {4'h0, raw_rd, 6'h00, eio_scale(raw_rd)};
        end else if (pg == `EIO_PG_EVENT) begin
          rd = {22'h00_0000, s.evval[idx]};
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // write strobes

  // byte lanes and the write moment
  always_comb begin
    bm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wm = wb_dat_i & bm;
    do_wr = (s.bus_st == eio_pkg::EIO_BUS_FETCH) && wb_we_i && hit;
    in_clr = 8'h00;
    out_clr = 8'h00;
    an_clr = 8'h00;
    irq_clr = 3'h0;
    // merged words; unselected lanes keep their present bits
    dout_wr = eio_merge({24'h00_0000, s.dout}, bm, wm);
    thr_wr = eio_merge({22'h00_0000, s.thresh[idx]}, bm, wm);
    if (do_wr) begin
      // write one to clear; unselected lanes clear nothing
      if (wb_adr_i == `EIO_OFF_IN_CHG) begin
        in_clr = wm[7:0];
      end
      if (wb_adr_i == `EIO_OFF_OUT_CHG) begin
        out_clr = wm[7:0];
      end
      if (wb_adr_i == `EIO_OFF_AN_CHG) begin
        an_clr = wm[7:0];
      end
      if (wb_adr_i == `EIO_OFF_IRQ_CLR) begin
        irq_clr = wm[2:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // analog check terms

  // distance of the new sum from the value of the last event
  // the distance is unsigned, so a rise and a fall count alike
  always_comb begin
    scaled = eio_scale(s.acc);
    if (scaled >= s.evval[s.chan]) begin
      delta = scaled - s.evval[s.chan];
    end else begin
      delta = s.evval[s.chan] - scaled;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s = s;
    an_set = 8'h00;

    // bus sequence: one fetch cycle lets the raw store answer
    unique case (s.bus_st)
      eio_pkg::EIO_BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          next_s.bus_st = eio_pkg::EIO_BUS_FETCH;
        end
      end
      eio_pkg::EIO_BUS_FETCH: begin
        // the read word is taken here, a cycle after the address stood
        next_s.bus_st = eio_pkg::EIO_BUS_ACK;
        next_s.ack = 1'b1;
        next_s.dat = wb_we_i ? 32'h0000_0000 : rd;
      end
      eio_pkg::EIO_BUS_ACK: begin
        next_s.bus_st = eio_pkg::EIO_BUS_IDLE;
        next_s.ack = 1'b0;
      end
    endcase

    // plain register writes
    // mode and enable take only lane zero; drive and thresholds merge lanes
    if (do_wr) begin
      if (wb_adr_i == `EIO_OFF_DOUT) begin
        next_s.dout = dout_wr[7:0];
      end
      if (wb_adr_i == `EIO_OFF_CONFIG && wb_sel_i[0]) begin
        next_s.ratio = wb_dat_i[`EIO_CFG_RATIO_BIT];
      end
      if (wb_adr_i == `EIO_OFF_IRQ_EN && wb_sel_i[0]) begin
        next_s.irq_en = wb_dat_i[2:0];
      end
      if (wb_adr_i[7:5] == `EIO_PG_THRESH && wb_adr_i[1:0] == 2'h0) begin
        next_s.thresh[idx] = thr_wr[9:0];
      end
    end

    // scan the channels without pause
    unique case (s.adc_st)
      eio_pkg::EIO_ADC_START: begin
        // the converter takes the request from this one cycle pulse
        next_s.adc_st = eio_pkg::EIO_ADC_WAIT;
      end
      eio_pkg::EIO_ADC_WAIT: begin
        // samples that arrive outside this state are dropped on purpose
        if (adc_valid_i) begin
          // four 10 bit samples sum to 12 bits
          next_s.acc = s.acc + {2'h0, adc_sample_i};
          next_s.cnt = s.cnt + 2'h1;
          if (s.cnt == `EIO_OVERSAMPLE_LAST) begin
            next_s.adc_st = eio_pkg::EIO_ADC_STORE;
          end else begin
            next_s.adc_st = eio_pkg::EIO_ADC_START;
          end
        end
      end
      eio_pkg::EIO_ADC_STORE: begin
        // the finished sum goes into the raw store in this cycle
        next_s.adc_st = eio_pkg::EIO_ADC_CHECK;
      end
      eio_pkg::EIO_ADC_CHECK: begin
        // strictly more than the threshold raises the event
        // the stored event value is the reference for the next move
        if (delta > s.thresh[s.chan]) begin
          next_s.evval[s.chan] = scaled;
          an_set[s.chan] = 1'b1;
        end
        next_s.chan = s.chan + 3'h1; // wraps after seven
        next_s.acc = 12'h000;
        next_s.cnt = 2'h0;
        next_s.adc_st = eio_pkg::EIO_ADC_START;
      end
    endcase

    // change events; a set in the clearing cycle wins
    // so software that clears a bit just as a new event comes in
    // still sees that event instead of losing it
    in_set = din_level ^ s.din_prev;
    out_set = next_s.dout ^ s.dout;
    next_s.din_prev = din_level;
    next_s.in_chg = (s.in_chg & ~in_clr) | in_set;
    next_s.out_chg = (s.out_chg & ~out_clr) | out_set;
    next_s.an_chg = (s.an_chg & ~an_clr) | an_set;
    next_s.irq_stat = s.irq_stat & ~irq_clr;
    next_s.irq_stat[`EIO_IRQ_IN_BIT] = next_s.irq_stat[`EIO_IRQ_IN_BIT] | (|in_set);
    next_s.irq_stat[`EIO_IRQ_OUT_BIT] = next_s.irq_stat[`EIO_IRQ_OUT_BIT] | (|out_set);
    next_s.irq_stat[`EIO_IRQ_AN_BIT] = next_s.irq_stat[`EIO_IRQ_AN_BIT] | (|an_set);
  end

  //////////////////////////////////////////////////////////////////////
  // state register

  // reset values; thresholds start at their default
  // the scan starts at channel zero in the first cycle after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.bus_st <= eio_pkg::EIO_BUS_IDLE;
      s.adc_st <= eio_pkg::EIO_ADC_START;
      s.dout <= `EIO_DOUT_RST;
      s.ratio <= `EIO_RATIO_RST;
      for (int i = 0; i < 8; i++) begin
        s.thresh[i] <= `EIO_THRESH_RST;
      end
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  // both bus outputs come straight from flip-flops
  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
  assign dout_o = s.dout;
  // start is a decode of the scan state, high one cycle per sample
  assign adc_start_o = (s.adc_st == eio_pkg::EIO_ADC_START);
  assign adc_chan_o = s.chan;
  assign adc_ref_ratio_o = s.ratio;
  // a level; it falls only when software clears or masks the status
  assign irq_o = |(s.irq_stat & s.irq_en);

endmodule : eio_io_unit

// File: verilog/eio_defines.svh
// constants of the eight channel io readout unit
//////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////
`ifndef EIO_DEFINES_SVH
`define EIO_DEFINES_SVH

// byte offsets of the single registers
`define EIO_OFF_DIN 8'h00
`define EIO_OFF_DOUT 8'h04
`define EIO_OFF_CONFIG 8'h08
`define EIO_OFF_IRQ_STAT 8'h0C
`define EIO_OFF_IRQ_CLR 8'h10
`define EIO_OFF_IRQ_EN 8'h14
`define EIO_OFF_IN_CHG 8'h18
`define EIO_OFF_OUT_CHG 8'h1C
`define EIO_OFF_AN_CHG 8'h20
// pages of eight words, address bits 7:5
`define EIO_PG_THRESH 3'h2
`define EIO_PG_ANALOG 3'h3
`define EIO_PG_EVENT 3'h4

// field positions
`define EIO_CFG_RATIO_BIT 0
`define EIO_IRQ_IN_BIT 0
`define EIO_IRQ_OUT_BIT 1
`define EIO_IRQ_AN_BIT 2
`define EIO_AN_RAW_LSB 16

// reset values
`define EIO_THRESH_RST 10'h00A
`define EIO_RATIO_RST 1'h0
`define EIO_DOUT_RST 8'h00

// scaling: raw * 1001 / 4096 maps 4095 onto 1000
`define EIO_SCALE_MUL 22'h0003E9
`define EIO_OVERSAMPLE_LAST 2'h3

// timing
`define EIO_CLK_NS 50
`define EIO_DIN_FILT_NS 100000
`define EIO_DIN_FILT_CYC ((`EIO_DIN_FILT_NS + `EIO_CLK_NS - 1) / `EIO_CLK_NS)

`endif

// File: verilog/eio_pkg.sv
// types of the eight channel io readout unit
package eio_pkg;

  // register bus sequence
  typedef enum logic [1:0] {EIO_BUS_IDLE, EIO_BUS_FETCH, EIO_BUS_ACK} eio_bus_state_type;

  // analog scan sequence
  typedef enum logic [1:0] {EIO_ADC_START, EIO_ADC_WAIT, EIO_ADC_STORE, EIO_ADC_CHECK}
    eio_adc_state_type;

  // all state of the top unit
  typedef struct packed {
    eio_bus_state_type bus_st;
    logic ack;
    logic [31:0] dat;
    logic [7:0] dout;
    logic [7:0] din_prev;
    logic ratio;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [7:0] in_chg;
    logic [7:0] out_chg;
    logic [7:0] an_chg;
    logic [7:0][9:0] thresh;
    logic [7:0][9:0] evval;
    eio_adc_state_type adc_st;
    logic [2:0] chan;
    logic [11:0] acc;
    logic [1:0] cnt;
  } eio_core_type;

  // state of the input filter
  typedef struct packed {
    logic [7:0] level;
    logic [7:0][11:0] cnt;
  } eio_filt_type;

  // state of the raw value store
  typedef struct packed {
    logic [7:0][11:0] words;
    logic [11:0] rdata;
  } eio_mem_type;

endpackage : eio_pkg

// File: verilog/eio_din_filter.sv
// noise filter for the eight digital inputs
`timescale 1ns/1ns
`include "eio_defines.svh"

module eio_din_filter (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // raw pins, high while activated
  input wire logic [7:0] raw_i,
  // filtered levels
  output logic [7:0] level_o
);

  localparam logic [11:0] FILT_LAST = 12'(`EIO_DIN_FILT_CYC - 1);

  eio_pkg::eio_filt_type s; // registered state
  eio_pkg::eio_filt_type next_s; // next state

  // a level is taken only after it stood still for the whole filter time
  always_comb begin
    next_s = s;
    for (int i = 0; i < 8; i++) begin
      if (raw_i[i] == s.level[i]) begin
        next_s.cnt[i] = 12'h000; // glitch ends, restart
      end else if (s.cnt[i] == FILT_LAST) begin
        next_s.level[i] = raw_i[i];
        next_s.cnt[i] = 12'h000;
      end else begin
        next_s.cnt[i] = s.cnt[i] + 12'h001;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level_o = s.level;

endmodule : eio_din_filter

// File: verilog/eio_raw_mem.sv
// store of the eight raw analog values
`timescale 1ns/1ns

module eio_raw_mem (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // write port
  input wire logic we_i,
  input wire logic [2:0] waddr_i,
  input wire logic [11:0] wdata_i,
  // read port, data one cycle after address
  input wire logic [2:0] raddr_i,
  output logic [11:0] rdata_o
);

  eio_pkg::eio_mem_type s; // registered state
  eio_pkg::eio_mem_type next_s; // next state

  // read first: a read of the word being written sees the old word
  always_comb begin
    next_s = s;
    next_s.rdata = s.words[raddr_i];
    if (we_i) begin
      next_s.words[waddr_i] = wdata_i;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;

endmodule : eio_raw_mem

// File: testbench/eio_adc_model.sv
// converter model answering the readout unit's scan requests
`timescale 1ns/1ns

module eio_adc_model (
  // clock
  input wire logic clk_i,
  // conversion request
  input wire logic start_i,
  input wire logic [2:0] chan_i,
  // conversion answer
  output logic [9:0] sample_o,
  output logic valid_o
);
  logic [9:0] lvl [8]; // input level per channel, set by the bench
  logic [2:0] ch; // channel being converted
  int left; // conversions still owed
  int gap; // cycles until the next answer

  // quiet until the first request
  initial begin
    sample_o = 10'h000;
    valid_o = 1'b0;
    left = 0;
    gap = 1;
    ch = 3'h0;
  end

  // four conversions per request, each one to three cycles apart
  always @(posedge clk_i) begin
    valid_o <= 1'b0;
    sample_o <= ~sample_o; // no value is held between answers
    if (start_i) begin // a new request restarts the set
      ch <= chan_i;
      left <= 4;
      gap <= $urandom_range(3, 1);
    end else if (left > 0 && gap > 1) begin
      gap <= gap - 1;
    end else if (left > 0) begin
      valid_o <= 1'b1;
      sample_o <= lvl[ch];
      left <= left - 1;
      gap <= $urandom_range(3, 1);
    end
  end
endmodule : eio_adc_model

// File: testbench/eio_io_unit_asserts.sv
// assertion checker for the eight channel io readout unit
`timescale 1ns/1ns

module eio_io_unit_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // watched outputs
  input wire logic [7:0] dout_o,
  input wire logic adc_start_o,
  input wire logic [2:0] adc_chan_o,
  input wire logic adc_ref_ratio_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // a write acked at this address with lane zero open
  sequence s_wr(logic [7:0] a);
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == a;
  endsequence
  // two quiet cycles, then the acknowledge
  sequence s_late_ack;
    !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o;
  endsequence

  property p_ack_lat;
    $rose(wb_cyc_i && wb_stb_i) |-> s_late_ack;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("late or early ack");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  // the drive only moves on its own register write
  property p_dout_src;
    $changed(dout_o) |-> s_wr(8'h04) ##0 dout_o == wb_dat_i[7:0];
  endproperty
  a_dout_src: assert property (p_dout_src) else $error("drive moved alone");
  property p_ref_src;
    $changed(adc_ref_ratio_o) |-> s_wr(8'h08) ##0 adc_ref_ratio_o == wb_dat_i[0];
  endproperty
  a_ref_src: assert property (p_ref_src) else $error("reference moved alone");
  // mode is write only, so it reads as zero
  property p_cfg_hidden;
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h08 |-> wb_dat_o == 32'h0;
  endproperty
  a_cfg_hidden: assert property (p_cfg_hidden) else $error("mode read back");
  property p_start_pulse;
    adc_start_o |=> !adc_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start held");
  // the scan steps through channels in order, wrapping at seven
  property p_chan_step;
    $changed(adc_chan_o) |-> adc_start_o && adc_chan_o == $past(adc_chan_o) + 3'h1;
  endproperty
  a_chan_step: assert property (p_chan_step) else $error("channel skipped");
  property p_irq_mask;
    s_wr(8'h14) ##0 wb_dat_i[2:0] == 3'h0 |-> !irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
endmodule : eio_io_unit_asserts

bind eio_io_unit eio_io_unit_asserts chk_u (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .dout_o, .adc_start_o, .adc_chan_o, .adc_ref_ratio_o, .irq_o
);

// File: testbench/eio_io_unit_tb_top.sv
// self-checking bench of the eight channel io readout unit
`timescale 1ns/1ns

module eio_io_unit_tb_top;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o; // clock, reset, bus
  logic [7:0] wb_adr_i, din_i, dout_o, v, old, d, am;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd; // rd holds wb_dat_o at the ack of the last access, which is zero after a write
  logic adc_start_o, adc_ref_ratio_o, adc_valid_i, irq_o;
  logic [2:0] adc_chan_o;
  logic [9:0] adc_sample_i, e;
  int miscompares, checks;

  eio_io_unit dut_u (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .din_i, .dout_o, .adc_start_o, .adc_chan_o,
    .adc_ref_ratio_o, .adc_sample_i, .adc_valid_i, .irq_o
  );
  eio_adc_model adc_u (
    .clk_i, .start_i(adc_start_o), .chan_i(adc_chan_o),
    .sample_o(adc_sample_i), .valid_o(adc_valid_i)
  );

  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////
  // verdict, shared by the tests and the watchdog
  task automatic report_and_stop;
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  // compare one value with its expectation
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, s, x);
    end
  endtask : chk
  // one classic cycle, held until ack; only the watchdog ends a lost ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] x,
                    input logic [3:0] s);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= x;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // clear every sticky change and status bit
  task automatic clr;
    wb(1'b1, 8'h18, 32'hFF, 4'hF);
    wb(1'b1, 8'h1C, 32'hFF, 4'hF);
    wb(1'b1, 8'h20, 32'hFF, 4'hF);
    wb(1'b1, 8'h10, 32'h7, 4'hF);
  endtask : clr
  // scaled value of four equal samples
  function automatic logic [9:0] scaled(input logic [9:0] s);
    logic [23:0] p;
    p = {12'h000, s, 2'h0} * 24'h0003E9;
    return p[21:12];
  endfunction : scaled
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'h0189EF1E));
    miscompares = 0;
    checks = 0;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    din_i = 8'h00;
    adc_u.lvl[0] = 10'h000; // range ends, then levels around the default threshold
    adc_u.lvl[1] = 10'h3FF;
    adc_u.lvl[2] = 10'h00B;
    adc_u.lvl[3] = 10'h00C;
    for (int i = 4; i < 8; i++) begin
      adc_u.lvl[i] = 10'($urandom);
    end
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int k = 1; k >= 0; k--) begin
      wb(1'b1, 8'h08, 32'(k), 4'hF);
      chk({31'h0, adc_ref_ratio_o}, 32'(k));
      wb(1'b0, 8'h08, 32'h0, 4'hF); // mode is never read back
      chk(rd, 32'h0);
    end
    repeat (400) @(posedge clk_i);
    am = 8'h00;
    for (int i = 0; i < 8; i++) begin
      e = scaled(adc_u.lvl[i]);
      am[i] = e > 10'h00A;
      wb(1'b0, 8'h60 + 8'(4 * i), 32'h0, 4'hF);
      chk(rd, {4'h0, adc_u.lvl[i], 8'h00, e});
      wb(1'b0, 8'h80 + 8'(4 * i), 32'h0, 4'hF);
      chk(rd, {22'h0, am[i] ? e : 10'h000});
      wb(1'b0, 8'h40 + 8'(4 * i), 32'h0, 4'hF);
      chk(rd, 32'h0000000A);
    end
    wb(1'b0, 8'h20, 32'h0, 4'hF);
    chk(rd, {24'h0, am});
    wb(1'b0, 8'h0C, 32'h0, 4'hF);
    chk(rd, 32'h4);
    wb(1'b1, 8'h14, 32'h0, 4'hF);
    wb(1'b1, 8'h14, 32'h7, 4'hF);
    chk({31'h0, irq_o}, 32'h1);
    clr();
    chk({31'h0, irq_o}, 32'h0);
    for (int i = 0; i < 9; i++) begin // ninth slot is unmapped
      e = 10'($urandom);
      wb(1'b1, 8'h40 + 8'(4 * i) + ((i == 8) ? 8'h9C : 8'h00), {22'h0, e}, 4'hF);
      chk(rd, 32'h0);
      wb(1'b0, 8'h40 + 8'(4 * i) + ((i == 8) ? 8'h9C : 8'h00), 32'h0, 4'hF);
      chk(rd, (i == 8) ? 32'h0 : {22'h0, e});
    end
    old = 8'h00;
    for (int k = 0; k < 4; k++) begin // last pass rewrites the same drive
      v = (k == 3) ? old : 8'($urandom);
      wb(1'b1, 8'h04, {24'h0, v}, 4'hF);
      chk({24'h0, dout_o}, {24'h0, v});
      wb(1'b0, 8'h1C, 32'h0, 4'hF);
      chk(rd, {24'h0, v ^ old});
      chk({31'h0, irq_o}, {31'h0, v != old});
      wb(1'b0, 8'h04, 32'h0, 4'hF);
      chk(rd, {24'h0, v});
      clr();
      old = v;
    end
    wb(1'b1, 8'h04, {24'h0, ~old}, 4'hE); // lane zero closed
    chk({24'h0, dout_o}, {24'h0, old});
    d = 8'($urandom) | 8'h81;
    din_i <= d;
    repeat (1000) @(posedge clk_i);
    din_i <= 8'h00; // too short to pass the filter
    wb(1'b0, 8'h18, 32'h0, 4'hF);
    chk(rd, 32'h0);
    for (int k = 0; k < 2; k++) begin // activate, then release
      din_i <= (k == 0) ? d : 8'h00;
      repeat (2010) @(posedge clk_i);
      wb(1'b0, 8'h00, 32'h0, 4'hF);
      chk(rd, (k == 0) ? {24'h0, d} : 32'h0);
      wb(1'b0, 8'h18, 32'h0, 4'hF);
      chk(rd, {24'h0, d});
      chk({31'h0, irq_o}, 32'h1);
      clr();
    end
    report_and_stop();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    report_and_stop();
  end
endmodule : eio_io_unit_tb_top
